/* File: design/fpk_pkg.sv */
// package for the front-panel key and status controller
// assumes one 125 MHz clock and an APB master for software access
package fpk_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int DEBOUNCE_US = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int ACT_PULSE_US = 20;
  localparam int ACT_PULSE_CYC = ACT_PULSE_US * CLK_MHZ;
  // ****************************************************************
  // key codes
  // ****************************************************************
  localparam int NKEYS = 20;
  localparam logic [4:0] KEY_DIGIT0 = 5'h00;
  localparam logic [4:0] KEY_DIGIT3 = 5'h03;
  localparam logic [4:0] KEY_DIGIT4 = 5'h04;
  localparam logic [4:0] KEY_DIGIT9 = 5'h09;
  localparam logic [4:0] KEY_SHIFT = 5'h0a;
  localparam logic [4:0] KEY_UNITS = 5'h0b;
  localparam logic [4:0] KEY_ENTER = 5'h0c;
  localparam logic [4:0] KEY_UP = 5'h0d;
  localparam logic [4:0] KEY_DOWN = 5'h0e;
  localparam logic [4:0] KEY_SAVE = 5'h0f;
  localparam logic [4:0] KEY_RECALL = 5'h10;
  localparam logic [4:0] KEY_BACKSPACE = 5'h11;
  localparam logic [4:0] KEY_COPY = 5'h12;
  localparam logic [4:0] KEY_INHCFG = 5'h13;
  // secondary meanings sharing digit keys
  localparam logic [4:0] KEY_GPIB = 5'h01;
  localparam logic [4:0] KEY_STATUS = 5'h02;
  localparam logic [4:0] KEY_SERIAL = KEY_DIGIT4;
  localparam logic [4:0] KEY_DATA = 5'h05;
  localparam logic [4:0] KEY_INIT = 5'h06;
  localparam logic [4:0] KEY_CAL = 5'h07;
  localparam logic [4:0] KEY_BLANK = 5'h08;
  // ****************************************************************
  // menus and actions
  // ****************************************************************
  typedef enum logic [2:0] {
    FPK_MENU_NONE = 3'b000,
    FPK_MENU_LAN = 3'b001,
    FPK_MENU_GPIB = 3'b010,
    FPK_MENU_SERIAL = 3'b011,
    FPK_MENU_STATUS = 3'b100
  } fpk_menu_t;
  typedef enum logic [2:0] {
    FPK_ACT_NONE = 3'b000,
    FPK_ACT_COPY = 3'b001,
    FPK_ACT_INIT = 3'b010,
    FPK_ACT_CAL = 3'b011,
    FPK_ACT_INHIBIT = 3'b100
  } fpk_act_t;
  localparam logic [2:0] LAN_OPT_LAST = 3'h5;
  localparam logic [2:0] LAN_OPT_ENABLE = 3'h0;
  localparam logic [2:0] LAN_OPT_DYNAMIC = 3'h1;
  localparam logic [1:0] STAT_OPT_LAST = 2'h2;
  // ****************************************************************
  // apb register map
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_ACTIVE = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0c;
  localparam logic [7:0] REG_MENUVAL = 8'h10;
  localparam logic [3:0] BAUD_RESET = 4'h0;
  localparam logic [4:0] ADDR_RESET = 5'h0a;
  // serial frame is fixed; only baud is chosen
  localparam logic [3:0] SER_DATA_BITS = 4'h8;
  localparam logic [1:0] SER_STOP_BITS = 2'h1;
  localparam logic SER_PARITY_EN = 1'b0;
  localparam logic SER_RTSCTS_EN = 1'b1;
endpackage : fpk_pkg

/* File: design/fpk_key_cond.sv */
// one key input: synchroniser, debounce and press pulse
// assumes an asynchronous raw pin, active high while pressed
module fpk_key_cond #(
  parameter int STABLE_CYC = 1250
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw key and press event
  input wire logic key_raw,
  output logic key_press
);
  logic sync1_r;
  logic sync2_r;
  logic stable_r;
  logic [15:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= key_raw;
      sync2_r <= sync1_r;
    end
  end

  // counter restarts on every bounce; only a quiet level is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      stable_r <= 1'b0;
      key_press <= 1'b0;
    end else begin
      key_press <= 1'b0;
      if (sync2_r == stable_r) begin
        cnt_r <= 16'h0000;
      end else if (cnt_r == 16'(STABLE_CYC - 1)) begin
        cnt_r <= 16'h0000;
        stable_r <= sync2_r;
        key_press <= sync2_r;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  a_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      key_press |=> !key_press)
    else $error("key press longer than one cycle");
endmodule : fpk_key_cond

/* File: design/fpk_panel.sv */
// front-panel key decoder, mode handling and status lamps
// assumes raw keys from pins, remote and timebase events on pclk,
// and an apb master for configuration and status
//
// Behaviour
// - alternate key toggles alternate mode when no entry or action pending; lamp follows
// - dual keys act secondary in alternate mode, primary otherwise
// - secondary action clears alternate mode except network, gpib, serial, status
// - repeat menu key steps option; up and down change shown value
// - network menu: enable first, dynamic addressing next, then others
// - copy, init, cal and inhibit setup wait for enter
// - alternate key discards pending digits, mode unchanged
// - alternate key cancels pending action first, second press sets mode
// - reference lamp lit while reference present; lock requested then
// - timebase error lamp while reference present and unlocked
// - remote mode lights lamp and ignores keys but local key
// - digit three in remote returns to local, clears lamp
// - activity lamp pulses on every remote character
// - remote command error lamp held until status menu opened
// - serial frame fixed 8 data, 1 stop, no parity, rts/cts
// - address and baud changes apply after interface reset; power reset restores defaults
// - inhibit high suppresses trigger or output for the cycle
// - confirmed copy sends first channel pair to all others
// - data view shows latest remote data
//
// Local design decisions: the register addresses and the APB interface to the registers.
module fpk_panel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // key pins
  input wire logic [fpk_pkg::NKEYS-1:0] key_raw,
  // remote and timebase events
  input wire logic remote_req,
  input wire logic char_event,
  input wire logic cmd_error,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic ifc_reset,
  input wire logic ref_present,
  input wire logic ref_locked,
  input wire logic inhibit_pin,
  input wire logic cycle_start,
  // lamps
  output logic alt_lamp,
  output logic remote_lock_lamp,
  output logic link_activity_lamp,
  output logic iface_err_lamp,
  output logic ref_lamp,
  output logic tb_err_lamp,
  // actions and settings
  output logic lock_to_ref,
  output logic copy_first_pair_to_others,
  output logic load_defaults,
  output logic run_cal,
  output logic inhibit_setup,
  output logic panel_blank,
  output logic trig_suppress,
  output logic out_suppress,
  output logic [3:0] baud_active,
  output logic [4:0] gpib_addr_active,
  output logic [3:0] ser_data_bits,
  output logic [1:0] ser_stop_bits,
  output logic ser_parity_en,
  output logic ser_rtscts_en
);
  // ****************************************************************
  // key conditioning
  // ****************************************************************
  logic [fpk_pkg::NKEYS-1:0] press;
  logic [fpk_pkg::NKEYS-1:0] key_press_w;
  genvar gi;
  generate
    for (gi = 0; gi < fpk_pkg::NKEYS; gi++) begin : g_key
      fpk_key_cond #(.STABLE_CYC(fpk_pkg::DEBOUNCE_CYC)) u_key (
        .pclk(pclk),
        .presetn(presetn),
        .key_raw(key_raw[gi]),
        .key_press(key_press_w[gi])
      );
    end
  endgenerate
  assign press = key_press_w;

  // lowest index wins if two keys land in one cycle
  logic key_hit;
  logic [4:0] key_code;
  always_comb begin
    key_hit = 1'b0;
    key_code = 5'h00;
    for (int i = fpk_pkg::NKEYS - 1; i >= 0; i--) begin
      if (press[i]) begin
        key_hit = 1'b1;
        key_code = 5'(i);
      end
    end
  end

  // ****************************************************************
  // remote event sync
  // ****************************************************************
  logic [4:0] ev_s1_r;
  logic [4:0] ev_s2_r;
  logic char_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_r <= 5'h00;
      ev_s2_r <= 5'h00;
      char_d_r <= 1'b0;
    end else begin
      ev_s1_r <= {inhibit_pin, ref_locked, ref_present, remote_req,
                  char_event};
      ev_s2_r <= ev_s1_r;
      char_d_r <= ev_s2_r[0];
    end
  end
  logic inh_s;
  logic locked_s;
  logic refp_s;
  logic rem_req_s;
  logic char_rise;
  assign char_rise = ev_s2_r[0] & ~char_d_r;
  assign rem_req_s = ev_s2_r[1];
  assign refp_s = ev_s2_r[2];
  assign locked_s = ev_s2_r[3];
  assign inh_s = ev_s2_r[4];

  // ****************************************************************
  // remote lockout
  // ****************************************************************
  logic remote_r;
  logic rem_req_d_r;
  logic local_ret;
  assign local_ret = remote_r && key_hit &&
                     key_code == fpk_pkg::KEY_DIGIT3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_r <= 1'b0;
      rem_req_d_r <= 1'b0;
    end else begin
      rem_req_d_r <= rem_req_s;
      if (rem_req_s && !rem_req_d_r) begin
        remote_r <= 1'b1;
      end else if (local_ret) begin
        remote_r <= 1'b0;
      end
    end
  end
  assign remote_lock_lamp = remote_r;

  logic kev;
  assign kev = key_hit && !remote_r;

  // ****************************************************************
  // key decoder
  // ****************************************************************
  logic alt_r;
  logic entry_r;
  fpk_pkg::fpk_act_t pend_r;
  fpk_pkg::fpk_menu_t menu_r;
  logic [2:0] opt_r;
  logic [7:0] menu_val_r [0:fpk_pkg::LAN_OPT_LAST];
  logic [4:0] addr_sel_r;
  logic [3:0] baud_sel_r;
  logic is_digit;
  assign is_digit = key_code <= fpk_pkg::KEY_DIGIT9;

  logic status_open;
  assign status_open = kev && alt_r && !entry_r &&
                       key_code == fpk_pkg::KEY_STATUS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r <= 1'b0;
      entry_r <= 1'b0;
      pend_r <= fpk_pkg::FPK_ACT_NONE;
      menu_r <= fpk_pkg::FPK_MENU_NONE;
      opt_r <= 3'h0;
      panel_blank <= 1'b0;
      copy_first_pair_to_others <= 1'b0;
      load_defaults <= 1'b0;
      run_cal <= 1'b0;
      inhibit_setup <= 1'b0;
    end else begin
      copy_first_pair_to_others <= 1'b0;
      load_defaults <= 1'b0;
      run_cal <= 1'b0;
      inhibit_setup <= 1'b0;
      if (kev && key_code == fpk_pkg::KEY_SHIFT) begin
        if (entry_r) begin
          entry_r <= 1'b0;
        end else if (pend_r != fpk_pkg::FPK_ACT_NONE) begin
          pend_r <= fpk_pkg::FPK_ACT_NONE;
        end else begin
          alt_r <= !alt_r;
          menu_r <= fpk_pkg::FPK_MENU_NONE;
        end
      end else if (kev && pend_r != fpk_pkg::FPK_ACT_NONE) begin
        if (key_code == fpk_pkg::KEY_ENTER) begin
          pend_r <= fpk_pkg::FPK_ACT_NONE;
          unique case (pend_r)
            fpk_pkg::FPK_ACT_COPY: copy_first_pair_to_others <= 1'b1;
            fpk_pkg::FPK_ACT_INIT: load_defaults <= 1'b1;
            fpk_pkg::FPK_ACT_CAL: run_cal <= 1'b1;
            fpk_pkg::FPK_ACT_INHIBIT: inhibit_setup <= 1'b1;
            default: ;
          endcase
        end
      end else if (kev && alt_r && menu_r != fpk_pkg::FPK_MENU_NONE &&
                   !is_digit && key_code != fpk_pkg::KEY_SAVE &&
                   key_code != fpk_pkg::KEY_UP &&
                   key_code != fpk_pkg::KEY_DOWN) begin
        menu_r <= fpk_pkg::FPK_MENU_NONE;
        alt_r <= 1'b0;
      end else if (kev && alt_r) begin
        // secondary meanings
        if (menu_r == fpk_pkg::FPK_MENU_LAN &&
            key_code == fpk_pkg::KEY_SAVE) begin
          opt_r <= (opt_r == fpk_pkg::LAN_OPT_LAST) ? 3'h0
                   : opt_r + 3'h1;
        end else if (menu_r == fpk_pkg::FPK_MENU_STATUS &&
                     key_code == fpk_pkg::KEY_STATUS) begin
          opt_r <= (opt_r[1:0] == fpk_pkg::STAT_OPT_LAST) ? 3'h0
                   : opt_r + 3'h1;
        end else if ((menu_r == fpk_pkg::FPK_MENU_GPIB &&
                      key_code == fpk_pkg::KEY_GPIB) ||
                     (menu_r == fpk_pkg::FPK_MENU_SERIAL &&
                      key_code == fpk_pkg::KEY_SERIAL)) begin
          opt_r <= 3'h0; // single option menus stay put
        end else if (key_code == fpk_pkg::KEY_UP ||
                     key_code == fpk_pkg::KEY_DOWN) begin
          opt_r <= opt_r;
        end else begin
          opt_r <= fpk_pkg::LAN_OPT_ENABLE;
          unique case (key_code)
            fpk_pkg::KEY_SAVE: menu_r <= fpk_pkg::FPK_MENU_LAN;
            fpk_pkg::KEY_GPIB: menu_r <= fpk_pkg::FPK_MENU_GPIB;
            fpk_pkg::KEY_SERIAL: menu_r <= fpk_pkg::FPK_MENU_SERIAL;
            fpk_pkg::KEY_STATUS: menu_r <= fpk_pkg::FPK_MENU_STATUS;
            fpk_pkg::KEY_COPY: begin
              pend_r <= fpk_pkg::FPK_ACT_COPY;
              alt_r <= 1'b0;
            end
            fpk_pkg::KEY_INIT: begin
              pend_r <= fpk_pkg::FPK_ACT_INIT;
              alt_r <= 1'b0;
            end
            fpk_pkg::KEY_CAL: begin
              pend_r <= fpk_pkg::FPK_ACT_CAL;
              alt_r <= 1'b0;
            end
            fpk_pkg::KEY_INHCFG: begin
              pend_r <= fpk_pkg::FPK_ACT_INHIBIT;
              alt_r <= 1'b0;
            end
            fpk_pkg::KEY_BLANK: begin
              panel_blank <= !panel_blank;
              alt_r <= 1'b0;
            end
            default: alt_r <= 1'b0;
          endcase
        end
      end else if (kev) begin
        // primary meanings
        if (is_digit) begin
          entry_r <= 1'b1;
        end else if (key_code == fpk_pkg::KEY_UNITS ||
                     key_code == fpk_pkg::KEY_ENTER) begin
          entry_r <= 1'b0;
        end
        if (panel_blank) begin
          panel_blank <= 1'b0;
        end
      end
    end
  end
  assign alt_lamp = alt_r;

  // up and down change the value of the option shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i <= int'(fpk_pkg::LAN_OPT_LAST); i++) begin
        menu_val_r[i] <= 8'h00;
      end
      addr_sel_r <= fpk_pkg::ADDR_RESET;
      baud_sel_r <= fpk_pkg::BAUD_RESET;
    end else if (kev && alt_r && menu_r != fpk_pkg::FPK_MENU_NONE) begin
      if (key_code == fpk_pkg::KEY_UP) begin
        unique case (menu_r)
          fpk_pkg::FPK_MENU_GPIB: addr_sel_r <= addr_sel_r + 5'h01;
          fpk_pkg::FPK_MENU_SERIAL: baud_sel_r <= baud_sel_r + 4'h1;
          default: menu_val_r[opt_r] <= menu_val_r[opt_r] + 8'h01;
        endcase
      end else if (key_code == fpk_pkg::KEY_DOWN) begin
        unique case (menu_r)
          fpk_pkg::FPK_MENU_GPIB: addr_sel_r <= addr_sel_r - 5'h01;
          fpk_pkg::FPK_MENU_SERIAL: baud_sel_r <= baud_sel_r - 4'h1;
          default: menu_val_r[opt_r] <= menu_val_r[opt_r] - 8'h01;
        endcase
      end
    end
  end

  // selections only go live on an interface reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_active <= fpk_pkg::BAUD_RESET;
      gpib_addr_active <= fpk_pkg::ADDR_RESET;
    end else if (ifc_reset) begin
      baud_active <= baud_sel_r;
      gpib_addr_active <= addr_sel_r;
    end
  end
  assign ser_data_bits = fpk_pkg::SER_DATA_BITS;
  assign ser_stop_bits = fpk_pkg::SER_STOP_BITS;
  assign ser_parity_en = fpk_pkg::SER_PARITY_EN;
  assign ser_rtscts_en = fpk_pkg::SER_RTSCTS_EN;

  // ****************************************************************
  // status lamps
  // ****************************************************************
  logic [11:0] act_cnt_r;
  logic err_r;
  logic [7:0] rx_last_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_cnt_r <= 12'h000;
      err_r <= 1'b0;
      rx_last_r <= 8'h00;
    end else begin
      if (char_rise) begin
        act_cnt_r <= 12'(fpk_pkg::ACT_PULSE_CYC);
      end else if (act_cnt_r != 12'h000) begin
        act_cnt_r <= act_cnt_r - 12'h001;
      end
      if (cmd_error) begin
        err_r <= 1'b1;
      end else if (status_open) begin
        err_r <= 1'b0;
      end
      if (rx_valid) begin
        rx_last_r <= rx_data;
      end
    end
  end
  assign link_activity_lamp = act_cnt_r != 12'h000;
  assign iface_err_lamp = err_r;
  assign ref_lamp = refp_s;
  assign lock_to_ref = refp_s;
  assign tb_err_lamp = refp_s && !locked_s;

  // inhibit sampled at start of each delay cycle
  logic inh_cfg_out_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_suppress <= 1'b0;
      out_suppress <= 1'b0;
    end else if (cycle_start) begin
      trig_suppress <= inh_s && !inh_cfg_out_r;
      out_suppress <= inh_s && inh_cfg_out_r;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic wr_en;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inh_cfg_out_r <= 1'b0;
    end else if (wr_en && paddr == fpk_pkg::REG_CONFIG) begin
      inh_cfg_out_r <= pwdata[0];
    end
  end
  always_comb begin
    unique case (paddr)
      fpk_pkg::REG_STATUS: prdata = {22'h00_0000, pend_r, menu_r,
          err_r, remote_r, alt_r, entry_r};
      fpk_pkg::REG_CONFIG: prdata = {31'h0000_0000, inh_cfg_out_r};
      fpk_pkg::REG_ACTIVE: prdata = {23'h00_0000, gpib_addr_active,
          baud_active};
      fpk_pkg::REG_RXDATA: prdata = {24'h00_0000, rx_last_r};
      fpk_pkg::REG_MENUVAL: prdata = {21'h00_0000, opt_r, menu_val_r[opt_r]};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_err_hold: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_error |=> iface_err_lamp)
    else $error("error lamp not set");
  a_local_key: assert property (@(posedge pclk) disable iff (!presetn)
      local_ret && !(rem_req_s && !rem_req_d_r) |=> !remote_lock_lamp)
    else $error("local key ignored");
  a_remote_lock: assert property (@(posedge pclk) disable iff (!presetn)
      remote_r && key_hit |=> $stable(alt_r))
    else $error("key acted in remote");
  a_tb_err: assert property (@(posedge pclk) disable iff (!presetn)
      tb_err_lamp |-> ref_lamp)
    else $error("timebase error without reference");
  a_act_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      char_rise |=> link_activity_lamp [*8])
    else $error("activity pulse too short");
  a_pend_enter: assert property (@(posedge pclk) disable iff (!presetn)
      copy_first_pair_to_others |-> $past(key_code) == fpk_pkg::KEY_ENTER)
    else $error("copy fired without enter");
  a_alt_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      kev && key_code == fpk_pkg::KEY_SHIFT && !entry_r &&
      pend_r == fpk_pkg::FPK_ACT_NONE |=> alt_r != $past(alt_r))
    else $error("alternate mode not toggled");
  a_cancel_keep: assert property (@(posedge pclk) disable iff (!presetn)
      kev && key_code == fpk_pkg::KEY_SHIFT && entry_r |=> $stable(alt_r))
    else $error("cancel changed mode");
endmodule : fpk_panel

/* File: bench/fpk_panel_model.sv */
// keypad and link partner: chattering key contacts, character events
// assumes pclk from the bench; every pin changes just after a rising edge
module fpk_panel_model (
  // clock
  input wire logic pclk,
  // pins toward the panel
  output logic [fpk_pkg::NKEYS-1:0] key_raw,
  output logic char_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // contact model
  // ****************
  initial begin
    key_raw = '0;
    char_event = 1'b0;
  end
  // real domes chatter; five flips leave the contact inverted
  task automatic chatter(input logic [4:0] k);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      key_raw[k] <= ~key_raw[k];
    end
    repeat (1280) @(posedge pclk);
  endtask : chatter
  task automatic press(input logic [4:0] k);
    chatter(k);
    chatter(k);
  endtask : press
  task automatic chars();
    @(posedge pclk);
    char_event <= 1'b1;
    @(posedge pclk);
    char_event <= 1'b0;
  endtask : chars
endmodule : fpk_panel_model

/* File: bench/test_front_panel_key_status_controller.sv */
// self-checking bench for the front-panel key and status controller
// assumes the keypad model beside it; apb and events driven at posedge
module test_front_panel_key_status_controller;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // signals
  // ****************
  localparam logic [4:0] ACTK [4] = '{fpk_pkg::KEY_COPY, fpk_pkg::KEY_INIT,
    fpk_pkg::KEY_CAL, fpk_pkg::KEY_INHCFG};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, rx_data = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic remote_req = 0, cmd_error = 0, rx_valid = 0, ifc_reset = 0;
  logic ref_present = 0, ref_locked = 0, inhibit_pin = 0, cycle_start = 0;
  logic pready, pslverr, alt_lamp, remote_lock_lamp, link_activity_lamp;
  logic iface_err_lamp, ref_lamp, tb_err_lamp, lock_to_ref, panel_blank;
  logic trig_suppress, out_suppress, ser_parity_en, ser_rtscts_en;
  logic [3:0] act_p, baud_active, ser_data_bits;
  logic [4:0] gpib_addr_active;
  logic [1:0] ser_stop_bits;
  logic [fpk_pkg::NKEYS-1:0] key_raw;
  logic char_event;
  logic [15:0] lf = 16'hdb03;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  int pc [4] = '{0, 0, 0, 0};
  fpk_panel fpk_panel_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .key_raw, .remote_req,
    .char_event, .cmd_error, .rx_data, .rx_valid, .ifc_reset, .ref_present,
    .ref_locked, .inhibit_pin, .cycle_start, .alt_lamp, .remote_lock_lamp,
    .link_activity_lamp, .iface_err_lamp, .ref_lamp, .tb_err_lamp,
    .lock_to_ref, .copy_first_pair_to_others(act_p[0]),
    .load_defaults(act_p[1]), .run_cal(act_p[2]), .inhibit_setup(act_p[3]),
    .panel_blank, .trig_suppress, .out_suppress, .baud_active,
    .gpib_addr_active, .ser_data_bits, .ser_stop_bits, .ser_parity_en,
    .ser_rtscts_en);
  fpk_panel_model fpk_panel_model_inst (.pclk, .key_raw, .char_event);
  initial begin
    forever #4 pclk = ~pclk;
  end
  // action outputs are one-cycle pulses, so count them as they pass
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (act_p[i] === 1'b1) pc[i] <= pc[i] + 1;
    end
    if (cyc == 95000) begin
      error_cnt++;
      results();
    end
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic key(input logic [4:0] k);
    fpk_panel_model_inst.press(k);
  endtask : key
  task automatic cs();
    repeat (3) @(posedge pclk);
    cycle_start <= 1'b1;
    @(posedge pclk);
    cycle_start <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : cs
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask : tend
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'hfc, '0);
    chk("unmapped", {rd[30:0], pslverr}, 0);
    chk("reset", {alt_lamp, iface_err_lamp, remote_lock_lamp}, 0);
    chk("serial", {ser_data_bits, ser_stop_bits, ser_parity_en,
      ser_rtscts_en}, 8'h85);
    @(posedge pclk);
    ifc_reset <= 1'b1;
    @(posedge pclk);
    ifc_reset <= 1'b0;
    apb(1'b0, fpk_pkg::REG_ACTIVE, '0);
    chk("active", rd, 32'h0000_00a0);
    tend("reset");
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 1);
    key(fpk_pkg::KEY_COPY);
    chk("alt", alt_lamp, 0);
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 0);
    key(fpk_pkg::KEY_ENTER);
    chk("copy", pc[0], 0);
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 1);
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 0);
    key(fpk_pkg::KEY_DIGIT9);
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 0);
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 1);
    tend("shift");
    for (int i = 0; i < 4; i++) begin
      if (i > 0) key(fpk_pkg::KEY_SHIFT);
      key(ACTK[i]);
      chk("held", pc[i], 0);
      chk("alt", alt_lamp, 0);
      key(fpk_pkg::KEY_ENTER);
      chk("fire", pc[i], 1);
    end
    tend("actions");
    key(fpk_pkg::KEY_SHIFT);
    key(fpk_pkg::KEY_SAVE);
    apb(1'b0, fpk_pkg::REG_MENUVAL, '0);
    chk("opt", {alt_lamp, rd[10:8]}, 4'h8);
    key(fpk_pkg::KEY_SAVE);
    apb(1'b0, fpk_pkg::REG_MENUVAL, '0);
    chk("opt", {alt_lamp, rd[10:8]}, 4'h9);
    key(fpk_pkg::KEY_GPIB);
    key(fpk_pkg::KEY_UP);
    chk("active", {gpib_addr_active, baud_active}, 9'h0a0);
    key(fpk_pkg::KEY_BACKSPACE);
    @(posedge pclk);
    ifc_reset <= 1'b1;
    @(posedge pclk);
    ifc_reset <= 1'b0;
    @(posedge pclk);
    chk("active", {gpib_addr_active, baud_active}, 9'h0b0);
    tend("menu");
    @(posedge pclk);
    cmd_error <= 1'b1;
    @(posedge pclk);
    cmd_error <= 1'b0;
    key(fpk_pkg::KEY_SHIFT);
    chk("err", iface_err_lamp, 1);
    key(fpk_pkg::KEY_STATUS);
    chk("err", {iface_err_lamp, alt_lamp}, 1);
    key(fpk_pkg::KEY_BACKSPACE);
    key(fpk_pkg::KEY_SHIFT);
    key(fpk_pkg::KEY_BLANK);
    chk("blank", {panel_blank, alt_lamp}, 2);
    tend("error");
    remote_req <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("remote", remote_lock_lamp, 1);
    key(fpk_pkg::KEY_SHIFT);
    chk("alt", alt_lamp, 0);
    key(fpk_pkg::KEY_DIGIT3);
    chk("remote", remote_lock_lamp, 0);
    remote_req <= 1'b0;
    fpk_panel_model_inst.chars();
    repeat (2390) @(posedge pclk);
    chk("act", link_activity_lamp, 1);
    repeat (120) @(posedge pclk);
    chk("act", link_activity_lamp, 0);
    tend("remote");
    ref_present <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("ref", {ref_lamp, lock_to_ref, tb_err_lamp}, 3'h7);
    ref_locked <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("ref", {ref_lamp, lock_to_ref, tb_err_lamp}, 3'h6);
    ref_present <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("ref", {ref_lamp, tb_err_lamp}, 0);
    apb(1'b1, fpk_pkg::REG_CONFIG, 32'h0000_0001);
    inhibit_pin <= 1'b1;
    cs();
    chk("inh", {trig_suppress, out_suppress}, 1);
    apb(1'b1, fpk_pkg::REG_CONFIG, '0);
    cs();
    chk("inh", {trig_suppress, out_suppress}, 2);
    inhibit_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    cs();
    chk("inh", {trig_suppress, out_suppress}, 0);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      @(posedge pclk);
      rx_data <= lf[7:0];
      rx_valid <= 1'b1;
      @(posedge pclk);
      rx_valid <= 1'b0;
      apb(1'b0, fpk_pkg::REG_RXDATA, '0);
      chk("rx", rd, lf[7:0]);
    end
    tend("events");
    results();
  end
endmodule : test_front_panel_key_status_controller
